//--- rtl/mms_ctrl.sv
// mode, status indicator and serial format control with APB registers
// Functional notes
// - service input low forces serial port to 38400 baud, 8N1
// - service input leaves settings and mode alone; release restores format
// - service input low forces configuration commands enabled
// - indicator static high while searching for a new frame
// - indicator low for the whole of each received frame
// - indicator static low in light sleep
// - indicator toggles once per transmission while transmitting
// - indicator toggles every 1 s while configuration tool connected
// - indicator toggles every 500 ms when commands enabled by escape only
// - indicator toggles every 250 ms on fault; fault codes kept readable
// - fault enters fault handling and reboots 5 s later
// - radio transmit and receive blocked during malfunction
// - safe mode follows fault reboot; fault codes stay readable
// - receive searches for sync before switching to receive data
// - four power states; enable high with supply enters on state
// - enable low shuts down and clears escape, tool, sleep and power save; uart, band, command setting and fault code are kept
// - one of three bands active; configuration targets that band
// - band change applies at reboot; reboot returns to data mode
// - power save adapts sleep time to received packet timing
// - line change of at least 10 us wakes light sleep, answers OK
// - service input is active low, idle high
`include "mms_map.svh"
`timescale 1ns/10ps
`default_nettype none
module mms_ctrl #(
   parameter int unsigned MS_CYCLES = `MMS_MS_NS / `MMS_CLK_NS
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // host control pins
   input  wire logic        module_enable_in,
   input  wire logic        service_n_in,
   input  wire logic        host_transmit_line,
   // radio core events
   input  wire logic        sync_found_in,
   input  wire logic        frame_active_in,
   input  wire logic        tx_active_in,
   input  wire logic        tx_start_in,
   input  wire logic        fault_in,
   input  wire logic [7:0]  fault_code_in,
   // status and control outputs
   output logic             mode_indicator,
   output logic             radio_rx_en,
   output logic             radio_tx_en,
   output logic             power_down,
   output logic             reboot_pulse,
   output logic             wake_ok,
   output logic [1:0]       band_sel,
   output logic             config_command_en,
   // primary serial port format
   output logic [17:0]      port_baud,
   output logic [3:0]       port_data_bits,
   output logic [1:0]       port_parity,
   output logic             port_stop2
);
   localparam logic [17:0] MS_LAST = 18'(MS_CYCLES - 1);

   // millisecond tick divider
   logic [17:0] ms_cnt_ff, nxt_ms_cnt;
   logic        tick_ff, nxt_tick;
   always_comb begin
      nxt_tick   = (ms_cnt_ff == MS_LAST);
      nxt_ms_cnt = nxt_tick ? 18'h0_0000 : ms_cnt_ff + 18'h0_0001;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ms_cnt_ff <= 18'h0_0000;
         tick_ff   <= 1'b0;
      end else begin
         ms_cnt_ff <= nxt_ms_cnt;
         tick_ff   <= nxt_tick;
      end
   end

   // shared state, declared ahead of the groups that read it
   mms_pkg::mms_state_type state_ff, nxt_state;
   logic        cmdset_ff, esc_ff, tool_ff, sleep_req_ff, psave_ff;
   logic [1:0]  band_pend_ff, band_act_ff;
   logic [26:0] uart_ff;
   logic [7:0]  fcode_ff;
   logic        rx_data_ff, ps_sleep_ff, ind_ff, cmd_en_ff, reboot_ff;
   logic [2:0]  ps_n_ff;
   logic [15:0] tmin_ff;
   logic        svc_act, wr_ctrl, reboot_wr, fclr_wr;
   assign svc_act   = ~service_n_in;
   assign wr_ctrl   = psel & penable & pready & pwrite &
                      (paddr == `MMS_CTRL_OFS);
   assign reboot_wr = wr_ctrl & pwdata[`MMS_C_REBOOT];
   assign fclr_wr   = wr_ctrl & pwdata[`MMS_C_FCLR];

   // apb slave: data latched in setup, answer in the access cycle
   logic [31:0] prdata_ff, nxt_prdata;
   logic        pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
   always_comb begin
      nxt_prdata  = 32'h0000_0000;
      nxt_pslverr = 1'b0;
      nxt_pready  = psel & ~penable;
      case (paddr)
         `MMS_CTRL_OFS:  nxt_prdata = {22'h00_0000, band_pend_ff, 3'h0,
                            psave_ff, sleep_req_ff, tool_ff, esc_ff,
                            cmdset_ff};
         `MMS_UART_OFS:  nxt_prdata = {5'h00, uart_ff};
         `MMS_STAT_OFS:  nxt_prdata = {22'h00_0000, band_act_ff, ind_ff,
                            cmd_en_ff, svc_act, ps_sleep_ff, rx_data_ff,
                            state_ff};
         `MMS_FCODE_OFS: nxt_prdata = {24'h00_0000, fcode_ff};
         `MMS_PSAVE_OFS: nxt_prdata = {13'h0000, ps_n_ff, tmin_ff};
         default:        nxt_pslverr = psel & ~penable;
      endcase
      if (!(psel & ~penable)) begin
         nxt_prdata  = prdata_ff;
         nxt_pslverr = 1'b0;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff  <= 32'h0000_0000;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         prdata_ff  <= nxt_prdata;
         pready_ff  <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   // software settings; uart, command setting and band count as stored
   logic        nxt_cmdset, nxt_esc, nxt_tool, nxt_sleep_req, nxt_psave;
   logic [1:0]  nxt_band_pend, nxt_band_act;
   logic [26:0] nxt_uart;
   logic [7:0]  nxt_fcode;
   always_comb begin
      nxt_cmdset    = cmdset_ff;
      nxt_esc       = esc_ff;
      nxt_tool      = tool_ff;
      nxt_sleep_req = sleep_req_ff & (state_ff != mms_pkg::ST_LSLEEP);
      nxt_psave     = psave_ff;
      nxt_band_pend = band_pend_ff;
      nxt_band_act  = band_act_ff;
      nxt_uart      = uart_ff;
      nxt_fcode     = fcode_ff;
      if (state_ff == mms_pkg::ST_OFF) begin
         nxt_esc       = 1'b0;
         nxt_tool      = 1'b0;
         nxt_sleep_req = 1'b0;
         nxt_psave     = 1'b0;
      end
      if (reboot_ff) begin
         nxt_band_act = band_pend_ff;
         nxt_esc      = 1'b0;
      end
      if (wr_ctrl) begin
         nxt_cmdset = pwdata[`MMS_C_CMDSET];
         nxt_esc    = pwdata[`MMS_C_ESC];
         nxt_tool   = pwdata[`MMS_C_TOOL];
         nxt_psave  = pwdata[`MMS_C_PSAVE];
         nxt_sleep_req = nxt_sleep_req | pwdata[`MMS_C_SLEEP];
         // only codes below the band count are accepted
         if (pwdata[`MMS_C_BAND_HI:`MMS_C_BAND_LO] < `MMS_N_BANDS)
            nxt_band_pend = pwdata[`MMS_C_BAND_HI:`MMS_C_BAND_LO];
      end
      if (psel & penable & pready & pwrite & (paddr == `MMS_UART_OFS))
         nxt_uart = pwdata[26:0];
      if (fclr_wr)
         nxt_fcode = 8'h00;
      if (fault_in)
         nxt_fcode = fault_code_in; // capture wins over clear
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmdset_ff    <= 1'b0;
         esc_ff       <= 1'b0;
         tool_ff      <= 1'b0;
         sleep_req_ff <= 1'b0;
         psave_ff     <= 1'b0;
         band_pend_ff <= 2'h0;
         band_act_ff  <= 2'h0;
         uart_ff      <= `MMS_UART_RST;
         fcode_ff     <= 8'h00;
      end else begin
         cmdset_ff    <= nxt_cmdset;
         esc_ff       <= nxt_esc;
         tool_ff      <= nxt_tool;
         sleep_req_ff <= nxt_sleep_req;
         psave_ff     <= nxt_psave;
         band_pend_ff <= nxt_band_pend;
         band_act_ff  <= nxt_band_act;
         uart_ff      <= nxt_uart;
         fcode_ff     <= nxt_fcode;
      end
   end

   // wake detector: a new line level must hold for the minimum pulse
   logic        line_lvl_ff, nxt_line_lvl, wake_ff, nxt_wake;
   logic [11:0] line_cnt_ff, nxt_line_cnt;
   always_comb begin
      nxt_line_lvl = line_lvl_ff;
      nxt_wake     = 1'b0;
      nxt_line_cnt = 12'h000;
      if (host_transmit_line != line_lvl_ff) begin
         nxt_line_cnt = line_cnt_ff + 12'h001;
         if (line_cnt_ff == 12'(`MMS_WAKE_CYC - 1)) begin
            nxt_line_lvl = host_transmit_line;
            nxt_wake     = 1'b1;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_lvl_ff <= 1'b1;
         line_cnt_ff <= 12'h000;
         wake_ff     <= 1'b0;
      end else begin
         line_lvl_ff <= nxt_line_lvl;
         line_cnt_ff <= nxt_line_cnt;
         wake_ff     <= nxt_wake;
      end
   end

   // power state machine with fault, reboot and safe handling
   logic [15:0] st_ms_ff, nxt_st_ms;
   logic        nxt_reboot, wake_ok_ff, nxt_wake_ok;
   logic        rx_en_ff, nxt_rx_en, tx_en_ff, nxt_tx_en, pdn_ff, nxt_pdn;
   always_comb begin
      nxt_state   = state_ff;
      nxt_reboot  = 1'b0;
      nxt_wake_ok = 1'b0;
      case (state_ff)
         mms_pkg::ST_OFF:
            nxt_state = mms_pkg::ST_ON;
         mms_pkg::ST_ON: begin
            if (fault_in)
               nxt_state = mms_pkg::ST_FAULT;
            else if (reboot_wr)
               nxt_reboot = 1'b1;
            else if (sleep_req_ff)
               nxt_state = mms_pkg::ST_LSLEEP;
            else if (psave_ff)
               nxt_state = mms_pkg::ST_PSAVE;
         end
         mms_pkg::ST_LSLEEP: begin
            if (fault_in)
               nxt_state = mms_pkg::ST_FAULT;
            else if (wake_ff) begin
               nxt_state   = mms_pkg::ST_ON;
               nxt_wake_ok = 1'b1;
            end
         end
         mms_pkg::ST_PSAVE: begin
            if (fault_in)
               nxt_state = mms_pkg::ST_FAULT;
            else if (sleep_req_ff)
               nxt_state = mms_pkg::ST_LSLEEP;
            else if (!psave_ff)
               nxt_state = mms_pkg::ST_ON;
         end
         mms_pkg::ST_FAULT: begin
            if (tick_ff && st_ms_ff == 16'(`MMS_REBOOT_MS - 1)) begin
               nxt_state  = mms_pkg::ST_SAFE;
               nxt_reboot = 1'b1;
            end
         end
         mms_pkg::ST_SAFE:
            if (fclr_wr & ~fault_in)
               nxt_state = mms_pkg::ST_ON;
         default:
            nxt_state = mms_pkg::ST_OFF;
      endcase
      if (!module_enable_in)
         nxt_state = mms_pkg::ST_OFF;
      if (nxt_state != state_ff)
         nxt_st_ms = 16'h0000;
      else
         nxt_st_ms = st_ms_ff + {15'h0000, tick_ff};
      // radio held off in any fault condition
      nxt_rx_en = ~fault_in & ((state_ff == mms_pkg::ST_ON) |
                  (state_ff == mms_pkg::ST_PSAVE & ~ps_sleep_ff));
      nxt_tx_en = ~fault_in & (state_ff == mms_pkg::ST_ON);
      nxt_pdn   = (nxt_state == mms_pkg::ST_OFF);
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff   <= mms_pkg::ST_OFF;
         st_ms_ff   <= 16'h0000;
         reboot_ff  <= 1'b0;
         wake_ok_ff <= 1'b0;
         rx_en_ff   <= 1'b0;
         tx_en_ff   <= 1'b0;
         pdn_ff     <= 1'b1;
      end else begin
         state_ff   <= nxt_state;
         st_ms_ff   <= nxt_st_ms;
         reboot_ff  <= nxt_reboot;
         wake_ok_ff <= nxt_wake_ok;
         rx_en_ff   <= nxt_rx_en;
         tx_en_ff   <= nxt_tx_en;
         pdn_ff     <= nxt_pdn;
      end
   end

   // receive function and power save interval study
   logic        nxt_rx_data, nxt_ps_sleep, rx_start, rx_end;
   logic [2:0]  nxt_ps_n;
   logic [6:0]  ps_cyc_ff, nxt_ps_cyc;
   logic [15:0] nxt_tmin, gap_ff, nxt_gap, len_ff, nxt_len;
   logic [15:0] txlen_ff, nxt_txlen, slp_ff, nxt_slp, marg, slen;
   logic [16:0] lim;
   assign rx_start = sync_found_in & ~rx_data_ff & rx_en_ff;
   assign rx_end   = rx_data_ff & ~frame_active_in;
   always_comb begin
      marg = (tmin_ff >> 3) + 16'(`MMS_MARG_MS);
      slen = (tmin_ff > marg + txlen_ff) ? tmin_ff - marg - txlen_ff
                                         : 16'h0000;
      lim  = {1'b0, tmin_ff} + {1'b0, marg} + 17'(`MMS_OVL_MS);
      nxt_rx_data  = (rx_data_ff | rx_start) & ~rx_end & rx_en_ff;
      nxt_ps_n     = ps_n_ff;
      nxt_tmin     = tmin_ff;
      nxt_ps_sleep = ps_sleep_ff;
      nxt_slp      = slp_ff;
      nxt_ps_cyc   = ps_cyc_ff;
      nxt_txlen    = rx_end ? len_ff : txlen_ff;
      nxt_gap = (tick_ff & ~&gap_ff) ? gap_ff + 16'h0001 : gap_ff;
      nxt_len = (tick_ff & rx_data_ff) ? len_ff + 16'h0001 : len_ff;
      if (rx_start) begin
         if (ps_n_ff != 3'h0 && gap_ff < tmin_ff)
            nxt_tmin = gap_ff;
         if (ps_n_ff != 3'(`MMS_STUDY_PKTS))
            nxt_ps_n = ps_n_ff + 3'h1;
         nxt_gap = 16'h0000;
         nxt_len = 16'h0000;
      end
      if (rx_end && ps_n_ff == 3'(`MMS_STUDY_PKTS)) begin
         nxt_ps_sleep = 1'b1;
         nxt_slp      = slen;
      end
      if (ps_sleep_ff & tick_ff) begin
         if (slp_ff == 16'h0000) begin
            nxt_ps_sleep = 1'b0;
            nxt_ps_cyc   = ps_cyc_ff + 7'h01;
         end else
            nxt_slp = slp_ff - 16'h0001;
      end
      // study restarts after the cycle limit or on a missed slot
      if ((ps_sleep_ff & tick_ff & slp_ff == 16'h0000 &
           ps_cyc_ff == 7'(`MMS_RESTUDY_CYC - 1)) |
          (~ps_sleep_ff & ps_n_ff == 3'(`MMS_STUDY_PKTS) &
           {1'b0, gap_ff} > lim) | (state_ff != mms_pkg::ST_PSAVE)) begin
         nxt_ps_n     = 3'h0;
         nxt_tmin     = 16'hFFFF;
         nxt_ps_cyc   = 7'h00;
         nxt_ps_sleep = nxt_ps_sleep & (state_ff == mms_pkg::ST_PSAVE);
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_data_ff  <= 1'b0;
         ps_n_ff     <= 3'h0;
         tmin_ff     <= 16'hFFFF;
         ps_sleep_ff <= 1'b0;
         slp_ff      <= 16'h0000;
         ps_cyc_ff   <= 7'h00;
         txlen_ff    <= 16'h0000;
         gap_ff      <= 16'h0000;
         len_ff      <= 16'h0000;
      end else begin
         rx_data_ff  <= nxt_rx_data;
         ps_n_ff     <= nxt_ps_n;
         tmin_ff     <= nxt_tmin;
         ps_sleep_ff <= nxt_ps_sleep;
         slp_ff      <= nxt_slp;
         ps_cyc_ff   <= nxt_ps_cyc;
         txlen_ff    <= nxt_txlen;
         gap_ff      <= nxt_gap;
         len_ff      <= nxt_len;
      end
   end

   // status indicator: pattern chosen by priority, then driven
   mms_pkg::mms_pat_type pat_ff, nxt_pat;
   logic [9:0]  blk_ff, nxt_blk, per;
   logic        nxt_ind;
   always_comb begin
      if (state_ff == mms_pkg::ST_FAULT || state_ff == mms_pkg::ST_SAFE)
         nxt_pat = mms_pkg::PAT_FAULT;
      else if (tool_ff)
         nxt_pat = mms_pkg::PAT_TOOL;
      else if (esc_ff & ~cmdset_ff)
         nxt_pat = mms_pkg::PAT_ESC;
      else if (state_ff == mms_pkg::ST_LSLEEP || state_ff == mms_pkg::ST_OFF)
         nxt_pat = mms_pkg::PAT_LOW;
      else if (tx_active_in)
         nxt_pat = mms_pkg::PAT_TX;
      else if (rx_data_ff)
         nxt_pat = mms_pkg::PAT_RX;
      else
         nxt_pat = mms_pkg::PAT_HIGH;
      case (pat_ff)
         mms_pkg::PAT_TOOL:  per = 10'(`MMS_TOOL_MS);
         mms_pkg::PAT_ESC:   per = 10'(`MMS_ESC_MS);
         mms_pkg::PAT_FAULT: per = 10'(`MMS_FAULT_MS);
         default:            per = 10'h3FF;
      endcase
      nxt_blk = blk_ff;
      nxt_ind = ind_ff;
      case (pat_ff)
         mms_pkg::PAT_HIGH: nxt_ind = 1'b1;
         mms_pkg::PAT_LOW:  nxt_ind = 1'b0;
         mms_pkg::PAT_RX:   nxt_ind = 1'b0;
         mms_pkg::PAT_TX:   nxt_ind = ind_ff ^ tx_start_in;
         default: begin
            if (tick_ff) begin
               if (blk_ff == per - 10'h001) begin
                  nxt_blk = 10'h000;
                  nxt_ind = ~ind_ff;
               end else
                  nxt_blk = blk_ff + 10'h001;
            end
         end
      endcase
      // a fresh pattern restarts its interval from a known level
      if (nxt_pat != pat_ff) begin
         nxt_blk = 10'h000;
         nxt_ind = (nxt_pat != mms_pkg::PAT_LOW &&
                    nxt_pat != mms_pkg::PAT_RX);
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pat_ff <= mms_pkg::PAT_LOW;
         blk_ff <= 10'h000;
         ind_ff <= 1'b0;
      end else begin
         pat_ff <= nxt_pat;
         blk_ff <= nxt_blk;
         ind_ff <= nxt_ind;
      end
   end

   // serial format: service input overrides without touching settings
   logic [17:0] baud_ff, nxt_baud;
   logic [3:0]  dbits_ff, nxt_dbits;
   logic [1:0]  par_ff, nxt_par;
   logic        stop2_ff, nxt_stop2, nxt_cmd_en;
   always_comb begin
      nxt_cmd_en = cmdset_ff | esc_ff | svc_act;
      if (svc_act) begin
         nxt_baud  = `MMS_SVC_BAUD;
         nxt_dbits = `MMS_SVC_DBITS;
         nxt_par   = 2'h0;
         nxt_stop2 = 1'b0;
      end else begin
         nxt_baud  = uart_ff[`MMS_U_BAUD_HI:0];
         nxt_dbits = uart_ff[`MMS_U_DBITS_HI:`MMS_U_DBITS_LO];
         nxt_par   = uart_ff[`MMS_U_PAR_HI:`MMS_U_PAR_LO];
         nxt_stop2 = uart_ff[`MMS_U_STOP2];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         baud_ff   <= `MMS_SVC_BAUD;
         dbits_ff  <= `MMS_SVC_DBITS;
         par_ff    <= 2'h0;
         stop2_ff  <= 1'b0;
         cmd_en_ff <= 1'b0;
      end else begin
         baud_ff   <= nxt_baud;
         dbits_ff  <= nxt_dbits;
         par_ff    <= nxt_par;
         stop2_ff  <= nxt_stop2;
         cmd_en_ff <= nxt_cmd_en;
      end
   end

   // outputs straight from flip-flops
   assign prdata            = prdata_ff;
   assign pready            = pready_ff;
   assign pslverr           = pslverr_ff;
   assign mode_indicator    = ind_ff;
   assign radio_rx_en       = rx_en_ff;
   assign radio_tx_en       = tx_en_ff;
   assign power_down        = pdn_ff;
   assign reboot_pulse      = reboot_ff;
   assign wake_ok           = wake_ok_ff;
   assign band_sel          = band_act_ff;
   assign config_command_en = cmd_en_ff;
   assign port_baud         = baud_ff;
   assign port_data_bits    = dbits_ff;
   assign port_parity       = par_ff;
   assign port_stop2        = stop2_ff;
endmodule // mms_ctrl
`default_nettype wire

//--- rtl/mms_map.svh
// register map, field positions, reset values and timing figures
`ifndef MMS_MAP_SVH
`define MMS_MAP_SVH
// register byte offsets
`define MMS_CTRL_OFS      8'h00
`define MMS_UART_OFS      8'h04
`define MMS_STAT_OFS      8'h08
`define MMS_FCODE_OFS     8'h0C
`define MMS_PSAVE_OFS     8'h10
// control register bits
`define MMS_C_CMDSET      0
`define MMS_C_ESC         1
`define MMS_C_TOOL        2
`define MMS_C_SLEEP       3
`define MMS_C_PSAVE       4
`define MMS_C_REBOOT      5
`define MMS_C_FCLR        6
`define MMS_C_BAND_LO     8
`define MMS_C_BAND_HI     9
// serial format register fields
`define MMS_U_BAUD_HI     17
`define MMS_U_DBITS_LO    20
`define MMS_U_DBITS_HI    23
`define MMS_U_PAR_LO      24
`define MMS_U_PAR_HI      25
`define MMS_U_STOP2       26
// reset values: 9600 baud, 8 data bits, no parity, 1 stop bit
`define MMS_UART_RST      27'h080_2580
`define MMS_N_BANDS       2'h3
// service format: 38400 baud, 8 data bits
`define MMS_SVC_BAUD      18'h0_9600
`define MMS_SVC_DBITS     4'h8
// timing, in the unit named
`define MMS_CLK_NS        4
`define MMS_MS_NS         1000000
`define MMS_WAKE_NS       10000
`define MMS_WAKE_CYC      ((`MMS_WAKE_NS + `MMS_CLK_NS - 1) / `MMS_CLK_NS)
`define MMS_TOOL_MS       1000
`define MMS_ESC_MS        500
`define MMS_FAULT_MS      250
`define MMS_REBOOT_MS     5000
`define MMS_MARG_MS       60
`define MMS_OVL_MS        100
`define MMS_STUDY_PKTS    4
`define MMS_RESTUDY_CYC   100
`endif

//--- rtl/mms_pkg.sv
// types shared by the mode and status control block
package mms_pkg;
   typedef enum logic [2:0] {
      ST_OFF, ST_ON, ST_LSLEEP, ST_PSAVE, ST_FAULT, ST_SAFE
   } mms_state_type;
   typedef enum logic [2:0] {
      PAT_HIGH, PAT_LOW, PAT_RX, PAT_TX, PAT_TOOL, PAT_ESC, PAT_FAULT
   } mms_pat_type;
endpackage

//--- verif/mms_host.sv
// host terminal model driving the control pins of the block
`timescale 1ns/10ps
`default_nettype none
module mms_host (
   // clock and requests from the bench
   input  wire logic pclk, en_req, svc_req, line_req,
   // control pins, idle at their pulled levels from time zero
   output logic      module_enable_in = 1'h0,
   output logic      service_n_in = 1'h1,
   output logic      host_transmit_line = 1'h1
);
   // pins move only just after an edge, so the block never sees a race
   always @(posedge pclk) begin
      module_enable_in <= en_req;
      service_n_in <= !svc_req;
      host_transmit_line <= line_req;
   end
endmodule // mms_host
`default_nettype wire

//--- verif/mms_ctrl_asserts.sv
// checker for the mode and status control block, bound to its ports
`timescale 1ns/10ps
`default_nettype none
module mms_ctrl_asserts (
   // clock, reset and apb handshake
   input wire logic        pclk, presetn, psel, penable, pready,
   // host pins and fault event
   input wire logic        module_enable_in, service_n_in, fault_in,
   // outputs under watch
   input wire logic        radio_rx_en, radio_tx_en, power_down,
   input wire logic        reboot_pulse, wake_ok, config_command_en,
   input wire logic [1:0]  band_sel, port_parity,
   input wire logic [17:0] port_baud
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // fault taken while the radio runs and power stays on
   sequence s_flt;
      fault_in && radio_tx_en && module_enable_in ##1 module_enable_in;
   endsequence
   property p_fmt; !service_n_in |=> port_baud == 18'h0_9600 &&
      !port_parity; endproperty
   a_fmt: assert property (p_fmt) else $error("service format");
   property p_cmd; !service_n_in |=> config_command_en; endproperty
   a_cmd: assert property (p_cmd) else $error("commands off");
   property p_flt; s_flt |=> !radio_tx_en && !radio_rx_en; endproperty
   a_flt: assert property (p_flt) else $error("radio on in fault");
   // shutdown is checked once the enable pin has been low for two edges
   property p_off; !module_enable_in[*2] |=> power_down && !radio_tx_en;
   endproperty
   a_off: assert property (p_off) else $error("not shut down");
   property p_rbt; reboot_pulse |=> !reboot_pulse; endproperty
   a_rbt: assert property (p_rbt) else $error("reboot pulse long");
   property p_wake; wake_ok |=> !wake_ok && !power_down; endproperty
   a_wake: assert property (p_wake) else $error("wake pulse");
   property p_band; band_sel != 2'h3; endproperty
   a_band: assert property (p_band) else $error("band code 3");
   property p_rdy; psel && !penable |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("pready late");
endmodule // mms_ctrl_asserts
bind mms_ctrl mms_ctrl_asserts u_chk (.*);
`default_nettype wire

//--- verif/mms_ctrl_tb.sv
// self-checking bench for the mode and status control block
`timescale 1ns/10ps
`default_nettype none
module mms_ctrl_tb;
   localparam int MS = 5; // a short millisecond keeps the run brief
   // bench drives, all set at time zero
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
   logic pwrite = 1'h0, en_req = 1'h0, svc_req = 1'h0, line_req = 1'h1;
   logic sync_found_in = 1'h0, frame_active_in = 1'h0, fault_in = 1'h0;
   logic tx_active_in = 1'h0, tx_start_in = 1'h0;
   logic [7:0] paddr = 8'h00, fault_code_in = 8'h00;
   logic [31:0] pwdata = 32'h0, q, u, seed = 32'h7BE, prdata;
   // observed outputs
   logic module_enable_in, service_n_in, host_transmit_line, serr;
   logic pready, pslverr, mode_indicator, radio_rx_en, radio_tx_en;
   logic power_down, reboot_pulse, wake_ok, config_command_en, port_stop2;
   logic [1:0] band_sel, port_parity;
   logic [3:0] port_data_bits;
   logic [17:0] port_baud;
   int err_total = 0, total_checks = 0, now = 0, t0, p;
   // clock, cycle count, host model and the block
   always #2 pclk = ~pclk;
   always @(posedge pclk) now <= now + 1;
   mms_host host (.*);
   mms_ctrl #(.MS_CYCLES(MS)) dut (.*);
   // xorshift step and millisecond spans
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic int cyc(input int ms);
      return ms * MS;
   endfunction
   task automatic close_out;
      if (err_total == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // a wait that ran out ends the run as a failure
   task automatic hang;
      err_total++;
      close_out;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // one apb transfer; a spare edge after it avoids double drives
   task automatic bus(input logic w, logic [7:0] a, logic [31:0] d);
      int n = 0;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 50);
      q = prdata;
      serr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (n >= 50) hang;
      @(posedge pclk);
   endtask
   // length of the third indicator phase, clear of any pattern restart
   task automatic per;
      logic l;
      for (int k = 0; k < 3; k++) begin
         l = mode_indicator;
         p = 0;
         while (mode_indicator === l && p < 20000) begin
            @(posedge pclk);
            p++;
         end
      end
      if (p >= 20000) hang;
   endtask
   // wait for wake_ok when k is set, else for reboot_pulse
   task automatic hit(input logic k);
      int n = 0;
      while ((k ? wake_ok : reboot_pulse) !== 1'h1 && n < 60000) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 60000) hang;
   endtask
   // reset, then the scenarios in turn
   initial begin
      wt(4);
      presetn <= 1'h1;
      en_req <= 1'h1;
      wt(6);
      chk("power_down", 32'h0, power_down);
      chk("indicator", 32'h1, mode_indicator);
      bus(1'h0, 8'h04, 32'h0);
      chk("uart", 32'h0802580, q);
      for (int i = 0; i < 3; i++) begin
         seed = xs(seed);
         u = {5'h00, seed[26], 1'h0, seed[24], 4'h7, 2'h0, seed[17:0]};
         bus(1'h1, 8'h04, u);
         svc_req <= 1'h1;
         wt(4);
         chk("baud", 32'h9600, port_baud);
         chk("8n1", 8'h40, {port_data_bits, port_parity, port_stop2});
         chk("cmd_en", 32'h1, config_command_en);
         bus(1'h0, 8'h04, 32'h0);
         chk("stored", u, q);
         svc_req <= 1'h0;
         wt(4);
         chk("restored", u[26:0], {port_stop2, port_parity, port_data_bits,
            2'h0, port_baud});
      end
      bus(1'h1, 8'h00, 32'h220);
      bus(1'h1, 8'h00, 32'h320);
      wt(4);
      bus(1'h0, 8'h08, 32'h0);
      chk("band", 32'hA01, {band_sel, q[9:8], 5'h0, q[2:0]});
      frame_active_in <= 1'h1;
      wt(4);
      chk("no_sync", 32'h1, mode_indicator);
      sync_found_in <= 1'h1;
      wt(4);
      chk("rx", 32'h0, mode_indicator);
      sync_found_in <= 1'h0;
      frame_active_in <= 1'h0;
      wt(4);
      chk("search", 32'h1, mode_indicator);
      tx_active_in <= 1'h1;
      tx_start_in <= 1'h1;
      wt(2);
      tx_start_in <= 1'h0;
      wt(1);
      chk("tx_toggle", 32'h0, mode_indicator);
      for (int i = 0; i < 2; i++) begin
         bus(1'h1, 8'h00, i ? 32'h2 : 32'h4);
         per();
         chk("blink", cyc(i ? 500 : 1000), p);
      end
      seed = xs(seed);
      fault_code_in <= seed[7:0];
      fault_in <= 1'h1;
      t0 = now;
      @(posedge pclk);
      fault_in <= 1'h0;
      wt(3);
      chk("radio", 32'h0, {radio_tx_en, radio_rx_en});
      per();
      chk("fault_blink", cyc(250), p);
      hit(1'h0);
      chk("reboot", cyc(5000), (now - t0 + 3) / 10 * 10);
      bus(1'h0, 8'h08, 32'h0);
      chk("safe", 32'h5, q[2:0]);
      bus(1'h0, 8'h0C, 32'h0);
      chk("code", seed[7:0], q);
      bus(1'h1, 8'h00, 32'h40);
      bus(1'h1, 8'h00, 32'h8);
      wt(4);
      chk("sleep", 32'h0, mode_indicator);
      line_req <= 1'h0;
      t0 = now;
      hit(1'h1);
      chk("wake", 32'h1, now - t0 >= 2500 && now - t0 <= 2512);
      bus(1'h0, 8'h14, 32'h0);
      chk("unmapped", 32'h2, {serr, |q});
      en_req <= 1'h0;
      wt(4);
      chk("off", 32'h1, power_down);
      close_out;
   end
endmodule // mms_ctrl_tb
`default_nettype wire
